// file: src/swd_pkg.sv
package swd_pkg;
  localparam logic [7:0] UNLOCK_KEY = 8'h87;
  localparam logic [7:0] EXIT_KEY = 8'haa;
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_PINSEL = 8'h2b;
  localparam logic [7:0] IDX_ACT = 8'h30;
  localparam logic [7:0] IDX_UNIT = 8'hf5;
  localparam logic [7:0] IDX_TMO = 8'hf6;
  localparam logic [7:0] IDX_EVT = 8'hf7;
  localparam logic [7:0] WDT_LDN = 8'h08;
  localparam logic [7:0] LDN_RST = 8'h00;
  localparam logic [7:0] PINSEL_RST = 8'h10;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] IDLE_RDATA = 8'hff;
  localparam int PINSEL_ALT_BIT = 4;
  localparam int ACT_BIT = 0;
  localparam int UNIT_MIN_BIT = 3;
  localparam int EVT_STAT_BIT = 4;
  localparam int EVT_KBD_BIT = 6;
  localparam int EVT_MSE_BIT = 7;
  localparam longint TICK_NS = 64'd1000000000;
  localparam longint CLK_NS = 64'd40;
  localparam int TICK_CYCLES = int'(TICK_NS / CLK_NS);
  localparam logic [5:0] SEC_PER_MIN = 6'd60;
  localparam int TOL_S = 2;

  typedef enum logic [1:0] {
    SWD_LOCKED = 2'b00,
    SWD_HALF = 2'b01,
    SWD_OPEN = 2'b10
  } swd_cfg_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic data_sel;
    logic [7:0] wdata;
  } swd_io_t;
endpackage

// file: src/swd_watchdog.sv
`timescale 1ns/100ps
// Functional notes
// - once active the watchdog counts and asserts its output at expiry
// - each retrigger restarts counting from the programmed interval
// - nonzero timeout write enables or refreshes, loading the value
// - count reaching zero fires the timeout output
// - zero timeout write disables at once, no later expiry
// - count-mode bit 3 picks seconds when clear, minutes when set
// - expiry may be up to two seconds off the programmed interval
// - index port selects a register, data port accesses it
// - two consecutive unlock bytes on index port enter configuration mode
// - exit byte on index port leaves configuration mode
// - unit number eight in select register routes unit accesses here
// - activation register bit 0 turns the watchdog unit on
// - pin-function bit 4 clear routes timeout onto the shared pin
// - event-control zero stops keyboard and mouse retriggering
module swd_watchdog #(
  parameter int TICK_CYC = swd_pkg::TICK_CYCLES
) (
  input wire logic CLOCK, // system clock
  input wire logic SYS_RST, // async reset, active high
  input wire swd_pkg::swd_io_t IO_REQ, // port strobes and write byte
  output logic [7:0] IO_RDATA, // read byte, valid cycle after rd
  input wire logic KBD_IRQ, // keyboard interrupt pin
  input wire logic MSE_IRQ, // mouse interrupt pin
  input wire logic ALT_FUNC, // alternate function for shared pin
  output logic TIMEOUT_PIN_N, // shared pin, low on timeout
  output logic WDT_EXPIRED // expiry level toward reset or nmi
);
  import swd_pkg::*;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // interrupt pins are asynchronous
  logic [1:0] kbd_sync;
  logic [1:0] mse_sync;
  logic kbd_last;
  logic mse_last;
  logic kbd_edge;
  logic mse_edge;

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      kbd_sync <= 2'b00;
      mse_sync <= 2'b00;
      kbd_last <= 1'b0;
      mse_last <= 1'b0;
    end else begin
      kbd_sync <= {kbd_sync[0], KBD_IRQ};
      mse_sync <= {mse_sync[0], MSE_IRQ};
      kbd_last <= kbd_sync[1];
      mse_last <= mse_sync[1];
    end
  end

  assign kbd_edge = kbd_sync[1] & ~kbd_last;
  assign mse_edge = mse_sync[1] & ~mse_last;

  // configuration access
  swd_cfg_t cfg;
  swd_cfg_t next_cfg;
  logic [7:0] index;
  logic [7:0] next_index;
  logic [7:0] ldn;
  logic [7:0] next_ldn;
  logic [7:0] pinsel;
  logic [7:0] next_pinsel;
  logic [7:0] act;
  logic [7:0] next_act;
  logic [7:0] unit;
  logic [7:0] next_unit;
  logic [7:0] evt;
  logic [7:0] next_evt;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic idx_wr;
  logic dat_wr;
  logic dat_rd;
  logic unit_sel;
  logic tmo_wr;
  logic expired;
  logic [7:0] cnt;

  assign idx_wr = IO_REQ.wr & ~IO_REQ.data_sel;
  assign dat_wr = IO_REQ.wr & IO_REQ.data_sel & (cfg == SWD_OPEN);
  assign dat_rd = IO_REQ.rd & IO_REQ.data_sel & (cfg == SWD_OPEN);
  assign unit_sel = hit(ldn, WDT_LDN);
  assign tmo_wr = dat_wr & unit_sel & hit(index, IDX_TMO);

  always_comb begin
    next_cfg = cfg;
    next_index = index;
    if (idx_wr) begin
      case (cfg)
        SWD_LOCKED: next_cfg = hit(IO_REQ.wdata, UNLOCK_KEY) ? SWD_HALF : SWD_LOCKED;
        SWD_HALF: next_cfg = hit(IO_REQ.wdata, UNLOCK_KEY) ? SWD_OPEN : SWD_LOCKED;
        SWD_OPEN: begin
          if (hit(IO_REQ.wdata, EXIT_KEY)) begin
            next_cfg = SWD_LOCKED;
          end else begin
            next_index = IO_REQ.wdata;
          end
        end
        default: next_cfg = SWD_LOCKED;
      endcase
    end
  end

  always_comb begin
    next_ldn = ldn;
    next_pinsel = pinsel;
    next_act = act;
    next_unit = unit;
    next_evt = evt;
    if (dat_wr) begin
      if (hit(index, IDX_LDN)) begin
        next_ldn = IO_REQ.wdata;
      end
      if (hit(index, IDX_PINSEL)) begin
        next_pinsel = IO_REQ.wdata;
      end
      if (unit_sel && hit(index, IDX_ACT)) begin
        next_act = IO_REQ.wdata;
      end
      if (unit_sel && hit(index, IDX_UNIT)) begin
        next_unit = IO_REQ.wdata;
      end
      if (unit_sel && hit(index, IDX_EVT)) begin
        next_evt = IO_REQ.wdata;
      end
    end
    // a fresh expiry beats a software clear of the status bit
    if (expired) begin
      next_evt[EVT_STAT_BIT] = 1'b1;
    end
  end

  always_comb begin
    next_rdata = rdata;
    if (IO_REQ.rd) begin
      next_rdata = IDLE_RDATA;
      if (dat_rd) begin
        case (index)
          IDX_LDN: next_rdata = ldn;
          IDX_PINSEL: next_rdata = pinsel;
          IDX_ACT: next_rdata = unit_sel ? act : IDLE_RDATA;
          IDX_UNIT: next_rdata = unit_sel ? unit : IDLE_RDATA;
          IDX_TMO: next_rdata = unit_sel ? cnt : IDLE_RDATA;
          IDX_EVT: next_rdata = unit_sel ? evt : IDLE_RDATA;
          default: next_rdata = IDLE_RDATA;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cfg <= SWD_LOCKED;
      index <= REG_RST;
      ldn <= LDN_RST;
      pinsel <= PINSEL_RST;
      act <= REG_RST;
      unit <= REG_RST;
      evt <= REG_RST;
      rdata <= IDLE_RDATA;
    end else begin
      cfg <= next_cfg;
      index <= next_index;
      ldn <= next_ldn;
      pinsel <= next_pinsel;
      act <= next_act;
      unit <= next_unit;
      evt <= next_evt;
      rdata <= next_rdata;
    end
  end

  // countdown; the prescaler restarts on every load and every retrigger, so the
  // first tick lands one full second after either, or after activation if loaded while off
  localparam int PW = $clog2(TICK_CYC + 1);
  logic [PW-1:0] pre;
  logic [PW-1:0] next_pre;
  logic [5:0] mins;
  logic [5:0] next_mins;
  logic [7:0] next_cnt;
  logic [7:0] reload;
  logic [7:0] next_reload;
  logic next_expired;
  logic running;
  logic sec_tick;
  logic step;
  logic retrig;

  assign running = act[ACT_BIT] & (cnt != 8'h00);
  assign sec_tick = running & (pre == PW'(TICK_CYC - 1));
  assign step = sec_tick & (~unit[UNIT_MIN_BIT] | (mins == SEC_PER_MIN - 6'd1));
  assign retrig = running & ((kbd_edge & evt[EVT_KBD_BIT]) | (mse_edge & evt[EVT_MSE_BIT]));

  always_comb begin
    next_pre = pre;
    next_mins = mins;
    next_cnt = cnt;
    next_reload = reload;
    next_expired = expired;
    if (tmo_wr) begin
      next_cnt = IO_REQ.wdata;
      next_reload = IO_REQ.wdata;
      next_pre = '0;
      next_mins = 6'd0;
      next_expired = 1'b0;
    end else if (retrig) begin
      next_cnt = reload;
      next_pre = '0;
      next_mins = 6'd0;
    end else if (running) begin
      next_pre = sec_tick ? '0 : pre + PW'(1);
      if (sec_tick) begin
        next_mins = (mins == SEC_PER_MIN - 6'd1) ? 6'd0 : mins + 6'd1;
      end
      if (step) begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          next_expired = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pre <= '0;
      mins <= 6'd0;
      cnt <= REG_RST;
      reload <= REG_RST;
      expired <= 1'b0;
    end else begin
      pre <= next_pre;
      mins <= next_mins;
      cnt <= next_cnt;
      reload <= next_reload;
      expired <= next_expired;
    end
  end

  assign IO_RDATA = rdata;
  assign WDT_EXPIRED = expired;
  // bit clear gives the pin to the watchdog
  assign TIMEOUT_PIN_N = pinsel[PINSEL_ALT_BIT] ? ALT_FUNC : ~expired;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  unlock_two_a: assert property (
    $rose(cfg == SWD_OPEN) |-> $past(cfg) == SWD_HALF && $past(idx_wr) && $past(IO_REQ.wdata) == UNLOCK_KEY)
    else $error("config mode opened without second unlock byte");

  exit_mode_a: assert property (
    cfg == SWD_OPEN && idx_wr && IO_REQ.wdata == EXIT_KEY |=> cfg == SWD_LOCKED ##1 cfg != SWD_OPEN)
    else $error("exit byte did not leave config mode");

  locked_data_a: assert property (
    cfg != SWD_OPEN && IO_REQ.rd |=> IO_RDATA == IDLE_RDATA)
    else $error("data port reached registers while locked");

  load_value_a: assert property (
    tmo_wr |=> cnt == $past(IO_REQ.wdata) && reload == $past(IO_REQ.wdata) && !expired)
    else $error("timeout write did not load count");

  // a fresh nonzero load right behind the zero write may restart the count legally
  zero_stop_a: assert property (
    tmo_wr && IO_REQ.wdata == 8'h00 |=> (!running && !expired)
      ##1 ((!running && !expired) || $past(tmo_wr))
      ##1 ((!running && !expired) || $past(tmo_wr) || $past(tmo_wr, 2)))
    else $error("zero timeout did not stop watchdog");

  // pin is looked at in the cycle the expiry level stands, before any reload can clear it
  expire_a: assert property (
    step && cnt == 8'h01 && !tmo_wr && !retrig |=> expired && cnt == 8'h00 && (!TIMEOUT_PIN_N || pinsel[4]))
    else $error("count reached zero without expiry");

  inactive_hold_a: assert property (
    !act[ACT_BIT] && !tmo_wr |=> $stable(cnt) && $stable(expired))
    else $error("inactive unit counted or expired");

  decrement_a: assert property (
    running && !tmo_wr && !retrig |=> cnt == $past(cnt) - ($past(step) ? 8'h01 : 8'h00))
    else $error("countdown step wrong");

  minute_hold_a: assert property (
    sec_tick && unit[3] && mins != 6'd59 && !tmo_wr && !retrig |=> $stable(cnt))
    else $error("minute mode stepped on a second tick");

  retrigger_a: assert property (
    retrig && !tmo_wr |=> cnt == reload && pre == '0)
    else $error("retrigger did not restart count");

  event_gate_a: assert property (
    evt[7:6] == 2'b00 && running && !tmo_wr && !step |=> cnt == $past(cnt))
    else $error("interrupt restarted count while disabled");

  unit_route_a: assert property (
    dat_wr && !unit_sel && index == IDX_ACT |=> $stable(act))
    else $error("unit register written with other unit selected");

  pin_route_a: assert property (
    !pinsel[4] |-> TIMEOUT_PIN_N == !WDT_EXPIRED)
    else $error("shared pin not carrying timeout");
endmodule

// file: verification/superio_watchdog_timer_bench.sv
`timescale 1ns/100ps
module superio_watchdog_timer_bench;
  import swd_pkg::*;
  localparam int TK = 4;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic alt_func = 1'b0;
  swd_io_t io_req;
  logic [7:0] io_rdata;
  logic kbd_irq;
  logic mse_irq;
  logic timeout_pin_n;
  logic wdt_expired;
  logic [7:0] v;
  int num_errors = 0;
  int comparisons = 0;
  always #20 clock = ~clock;
  swd_watchdog #(.TICK_CYC(TK)) uut (.CLOCK(clock), .SYS_RST(sys_rst), .IO_REQ(io_req), .IO_RDATA(io_rdata),
    .KBD_IRQ(kbd_irq), .MSE_IRQ(mse_irq), .ALT_FUNC(alt_func), .TIMEOUT_PIN_N(timeout_pin_n),
    .WDT_EXPIRED(wdt_expired));
  swd_host host (.clk(clock), .rdata(io_rdata), .io(io_req), .kbd(kbd_irq), .mse(mse_irq));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // entered just after the load edge; expiry due n cycles later
  task automatic expiry(input int n);
    repeat (n - 1) @(negedge clock);
    check(wdt_expired, 1'b0);
    @(negedge clock);
    check(wdt_expired, 1'b1);
    check(timeout_pin_n, 1'b0);
  endtask
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    alt_func = 1'b1;
    #1 check(timeout_pin_n, 1'b1);
    host.put(1'b0, UNLOCK_KEY);
    host.put(1'b0, IDX_TMO);
    host.put(1'b1, 8'h05);
    host.get(v);
    check(v, IDLE_RDATA);
    host.open_unit();
    host.put(1'b0, IDX_PINSEL);
    host.get(v);
    check(v, 8'h10);
    host.set(IDX_PINSEL, v & 8'hef);
    host.put(1'b0, IDX_PINSEL);
    host.get(v);
    check(v, 8'h00);
    alt_func = 1'b0;
    #1 check(timeout_pin_n, 1'b1);
    host.close();
    host.get(v);
    check(v, IDLE_RDATA);
    host.put(1'b0, UNLOCK_KEY);
    host.put(1'b0, UNLOCK_KEY);
    host.set(IDX_LDN, 8'h07);
    host.put(1'b0, IDX_TMO);
    host.get(v);
    check(v, IDLE_RDATA);
    host.set(IDX_LDN, WDT_LDN);
    host.set(IDX_ACT, 8'h01);
    host.set(IDX_EVT, 8'h00);
    host.set(IDX_TMO, 8'h03);
    expiry(3 * TK);
    host.set(IDX_TMO, 8'h03);
    @(negedge clock);
    check(wdt_expired, 1'b0);
    // refresh well inside the interval, leaving the tolerance margin
    host.set(IDX_TMO, 8'h03);
    expiry(3 * TK);
    host.set(IDX_TMO, 8'h02);
    host.set(IDX_TMO, 8'h00);
    repeat (3 * TK) @(negedge clock);
    check(wdt_expired, 1'b0);
    host.set(IDX_ACT, 8'h00);
    host.set(IDX_TMO, 8'h01);
    repeat (2 * TK) @(negedge clock);
    check(wdt_expired, 1'b0);
    host.set(IDX_ACT, 8'h01);
    expiry(TK);
    host.set(IDX_EVT, 8'h40);
    host.set(IDX_TMO, 8'h03);
    host.irq(1'b0);
    repeat (8) @(negedge clock);
    check(wdt_expired, 1'b0);
    host.set(IDX_EVT, 8'h00);
    host.set(IDX_TMO, 8'h03);
    host.irq(1'b1);
    expiry(3 * TK - 4);
    host.put(1'b0, IDX_UNIT);
    host.get(v);
    host.set(IDX_UNIT, (v & 8'hf7) | 8'h08);
    host.put(1'b0, IDX_UNIT);
    host.get(v);
    check(v, 8'h08);
    host.set(IDX_TMO, 8'h01);
    expiry(60 * TK);
    host.close();
    results();
  end
  // whole run is about 470 cycles
  initial begin
    #400000;
    num_errors++;
    results();
  end
endmodule

// file: verification/swd_host.sv
`timescale 1ns/100ps
module swd_host (
  input wire logic clk, // system clock
  input wire logic [7:0] rdata, // read byte from the device
  output swd_pkg::swd_io_t io, // strobes toward the device
  output logic kbd, // keyboard interrupt line
  output logic mse // mouse interrupt line
);
  import swd_pkg::*;
  initial begin
    io = '0;
    kbd = 1'b0;
    mse = 1'b0;
  end
  // released byte shows its inverse so a stale value cannot pass for a write
  task automatic put(input logic sel, input logic [7:0] b);
    @(negedge clk);
    io <= '{wr: 1'b1, rd: 1'b0, data_sel: sel, wdata: b};
    @(negedge clk);
    io <= '{wr: 1'b0, rd: 1'b0, data_sel: sel, wdata: ~b};
  endtask
  task automatic get(output logic [7:0] b);
    @(negedge clk);
    io <= '{wr: 1'b0, rd: 1'b1, data_sel: 1'b1, wdata: 8'h00};
    @(negedge clk);
    io <= '0;
    @(negedge clk);
    b = rdata;
  endtask
  task automatic open_unit();
    put(1'b0, UNLOCK_KEY);
    put(1'b0, UNLOCK_KEY);
    put(1'b0, IDX_LDN);
    put(1'b1, WDT_LDN);
    put(1'b0, IDX_ACT);
    put(1'b1, 8'h01);
  endtask
  task automatic set(input logic [7:0] idx, input logic [7:0] v);
    put(1'b0, idx);
    put(1'b1, v);
  endtask
  task automatic close();
    put(1'b0, EXIT_KEY);
  endtask
  // held three cycles so the two-stage sync sees it
  task automatic irq(input logic mouse);
    @(negedge clk);
    if (mouse)
      mse <= 1'b1;
    else
      kbd <= 1'b1;
    repeat (3) @(negedge clk);
    kbd <= 1'b0;
    mse <= 1'b0;
  endtask
endmodule
